// [pin_mux_pkg.sv]
// Purpose: Shared constants and carrier types for the expansion pin mux
// Assumes: One core clock; straps sampled as reset ends
// Notes: Pin groups travel as packed structs of out/enable
package pin_mux_pkg;

  // ==========================================================
  // Widths and field positions
  localparam int ROM_DATA_W = 8;
  localparam int UPPER_W = 8;
  localparam int LOW_W = 4;
  localparam int SYNC_CFG_W = 2;

  // Strap bit positions
  localparam int STRAP_W = 3;
  localparam int STRAP_ROM_TOP = 0;
  localparam int STRAP_BIT1 = 1;
  localparam int STRAP_BIOS_CS = 2;

  // Strap word reset value
  localparam logic [STRAP_W-1:0] STRAP_RESET = 3'h7;

  // Test bus positions
  localparam int TEST_W = 32;
  localparam int T_DATA_LSB = 0;
  localparam int T_RA6 = 8;
  localparam int T_RA5 = 9;
  localparam int T_RA4 = 10;
  localparam int T_LOW_LSB = 11;
  localparam int T_SEL = 15;
  localparam int T_UPPER_LSB = 24;

  // ==========================================================
  // Peripheral bus style
  typedef enum logic {
    STYLE_STROBE_DIR,
    STYLE_READ_WRITE
  } bus_style_t;

  // Shared pin function
  typedef enum logic [1:0] {
    FUNC_ROM,
    FUNC_VIDEO_MODULE,
    FUNC_TEST
  } pin_func_t;

  // One two-way 8-bit group
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } bus8_drv_t;

  // One two-way single pin
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drv_t;

  // Sync polarity configuration
  typedef struct packed {
    logic hsync_invert;
    logic vsync_invert;
  } sync_cfg_t;

endpackage

// [strap_capture.sv]
// Purpose: Capture board straps as system reset ends
// Assumes: Strap pins are stable around reset release
// Notes: Two-stage sync, captured once both stages hold pin levels
`timescale 1ns/10ps
module strap_capture (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [pin_mux_pkg::STRAP_W-1:0] strap_pins_i,
  output logic [pin_mux_pkg::STRAP_W-1:0] straps_o,
  output logic straps_valid_o
);
  import pin_mux_pkg::*;

  // ==========================================================
  // Pin synchroniser
  logic [STRAP_W-1:0] sync_a; // First stage
  logic [STRAP_W-1:0] sync_b; // Second stage
  logic taken; // Capture done
  logic fill_a, fill_b; // Sync stages hold pin levels

  // Two flip-flops before any use
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a <= STRAP_RESET;
      sync_b <= STRAP_RESET;
      fill_a <= 1'b0;
      fill_b <= 1'b0;
    end else begin
      sync_a <= strap_pins_i;
      sync_b <= sync_a;
      fill_a <= 1'b1;
      fill_b <= fill_a;
    end
  end

  // Capture once after release, then hold
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      straps_o <= STRAP_RESET;
      taken <= 1'b0;
    end else if (fill_b && !taken) begin
      straps_o <= sync_b; // RULE18
      taken <= 1'b1;
    end
  end

  assign straps_valid_o = taken;

  // Straps never change once taken
  strap_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $past(taken) |-> $stable(straps_o)) // RULE18
    else $error("straps changed after capture");

endmodule

// [rom_vmi_pin_mux.sv]
// Overview of operation
// RULE1: Video enable gates pixel bus, else video valid
// RULE2: Sync enable gates syncs, else general I/O
// RULE3: Dot clock enable gates clock, else vertical ref
// RULE4: Dot clock pin outputs clock, else pixel in
// RULE5: Blank pin two-way gated, else horizontal ref
// RULE6: Syncs have programmable polarity, float when disabled
// RULE7: Top address bit 15 or serial data
// RULE8: Dedicated pin is second serial clock
// RULE9: Upper address pins carry video, pixel, test
// RULE10: Bit six gives strobe or read, test
// RULE11: Bit five gives direction or write, test
// RULE12: Bit four takes acknowledge or ready
// RULE13: Low pins carry peripheral register address
// RULE14: Peripheral select driven in module mode, low while an access runs
// RULE15: ROM data doubles as peripheral data bus
// RULE16: BIOS select enables ROM; low strap disables
// RULE17: Low bit1 strap moves pixel bus to encoder
// RULE18: Straps captured as reset ends and held
// RULE19: Test function wins on the upper, bit 6/5/4, low address, select and data pins
//
// Purpose: Pin function multiplexer for the shared expansion pins
// Assumes: Core supplies pin values
// Notes: Two-way pins as out/enable, enable high drives
`timescale 1ns/10ps
module rom_vmi_pin_mux (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Mode controls
  input wire logic video_module_mode_i,
  input wire logic test_mode_i,
  input wire pin_mux_pkg::bus_style_t bus_style_i,
  input wire pin_mux_pkg::sync_cfg_t sync_cfg_i,
  // Core ROM access
  input wire logic [15:0] rom_addr_i,
  input wire logic rom_read_i,
  output logic [pin_mux_pkg::ROM_DATA_W-1:0] rom_data_o,
  output logic bios_large_o,
  output logic bios_present_o,
  output logic encoder_video_ok_o,
  // Core peripheral access
  input wire logic periph_req_i,
  input wire logic periph_write_i,
  input wire logic [pin_mux_pkg::LOW_W-1:0] periph_reg_addr_i,
  input wire logic [pin_mux_pkg::ROM_DATA_W-1:0] periph_wdata_i,
  output logic [pin_mux_pkg::ROM_DATA_W-1:0] periph_rdata_o,
  output logic periph_done_o,
  // Core video and feature data
  input wire logic [pin_mux_pkg::UPPER_W-1:0] pixel_data_i,
  input wire logic [pin_mux_pkg::UPPER_W-1:0] encoder_data_i,
  input wire logic dot_clock_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic blank_n_i,
  output logic [pin_mux_pkg::UPPER_W-1:0] video_in_bus_o,
  output logic video_valid_in_o,
  output logic vertical_ref_o,
  output logic horizontal_ref_o,
  output logic pixel_clock_in_o,
  output logic blank_in_o,
  // Core general I/O and serial port
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  output logic gpio_in_o,
  input wire logic serial_clock_drive_low_i,
  input wire logic serial_data_drive_low_i,
  output logic serial_clock_in_o,
  output logic serial_data_in_o,
  // Test bus
  input wire logic [pin_mux_pkg::TEST_W-1:0] test_out_i,
  input wire logic test_oe_i,
  output logic [pin_mux_pkg::TEST_W-1:0] test_in_o,
  // Pins
  input wire logic video_enable_n_i,
  input wire logic dot_clock_enable_n_i,
  input wire logic sync_blank_enable_n_i,
  output pin_mux_pkg::pin_drv_t sync_blank_enable_n_o,
  input wire logic dot_clock_pin_i,
  output pin_mux_pkg::pin_drv_t dot_clock_pin_o,
  input wire logic blank_n_pin_i,
  output pin_mux_pkg::pin_drv_t blank_n_pin_o,
  output pin_mux_pkg::pin_drv_t hsync_pin_o,
  output pin_mux_pkg::pin_drv_t vsync_pin_o,
  input wire logic rom_addr_top_i,
  output pin_mux_pkg::pin_drv_t rom_addr_top_o,
  input wire logic [pin_mux_pkg::UPPER_W-1:0] rom_addr_upper_i,
  output pin_mux_pkg::bus8_drv_t rom_addr_upper_o,
  input wire logic rom_addr_bit6_i,
  output pin_mux_pkg::pin_drv_t rom_addr_bit6_o,
  input wire logic rom_addr_bit5_i,
  output pin_mux_pkg::pin_drv_t rom_addr_bit5_o,
  input wire logic rom_addr_bit4_i,
  output pin_mux_pkg::pin_drv_t rom_addr_bit4_o,
  input wire logic [pin_mux_pkg::LOW_W-1:0] rom_addr_low_i,
  output logic [pin_mux_pkg::LOW_W-1:0] rom_addr_low_o,
  output logic [pin_mux_pkg::LOW_W-1:0] rom_addr_low_oe_o,
  input wire logic [2:0] rom_addr_mid_i,
  output logic [2:0] rom_addr_mid_o,
  input wire logic periph_select_n_i,
  output pin_mux_pkg::pin_drv_t periph_select_n_o,
  input wire logic [pin_mux_pkg::ROM_DATA_W-1:0] periph_data_bus_i,
  output pin_mux_pkg::bus8_drv_t periph_data_bus_o,
  input wire logic bios_select_n_i,
  output pin_mux_pkg::pin_drv_t bios_select_n_o,
  input wire logic second_serial_clock_i,
  output pin_mux_pkg::pin_drv_t second_serial_clock_o,
  output pin_mux_pkg::bus8_drv_t encoder_video_bus_o
);
  import pin_mux_pkg::*;

  // ==========================================================
  // Pin synchronisers
  localparam int SYNC_N = 38; // Width of synchronised pin word
  logic [SYNC_N-1:0] raw_pins; // Gathered pin inputs
  logic [SYNC_N-1:0] sync_a; // First stage, read only by second
  logic [SYNC_N-1:0] sync_b; // Second stage

  assign raw_pins = {video_enable_n_i, dot_clock_enable_n_i,
    sync_blank_enable_n_i, dot_clock_pin_i, blank_n_pin_i,
    rom_addr_top_i, rom_addr_upper_i, rom_addr_bit6_i, rom_addr_bit5_i,
    rom_addr_bit4_i, rom_addr_low_i, periph_select_n_i,
    periph_data_bus_i, second_serial_clock_i, rom_addr_mid_i,
    bios_select_n_i, 3'h0};

  // Two flops per pin
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_pins;
      sync_b <= sync_a;
    end
  end

  // Named synchronised pins
  wire s_ven_n = sync_b[37]; // Video enable or valid
  wire s_dcen_n = sync_b[36]; // Dot clock enable or vref
  wire s_sben_n = sync_b[35]; // Sync/blank enable
  wire s_dot_clock_pin = sync_b[34]; // Dot clock pin
  wire s_blank = sync_b[33]; // Blank pin
  wire s_top = sync_b[32]; // Top address pin
  wire [7:0] s_upper = sync_b[31:24]; // Upper address pins
  wire s_b6 = sync_b[23]; // Address bit 6
  wire s_b5 = sync_b[22]; // Address bit 5
  wire s_b4 = sync_b[21]; // Ack or ready
  wire [3:0] s_low = sync_b[20:17]; // Low address pins
  wire s_psel = sync_b[16]; // Peripheral select pin
  wire [7:0] s_data = sync_b[15:8]; // Data bus pins
  wire s_scl = sync_b[7]; // Serial clock pin

  // ==========================================================
  // Straps
  logic [STRAP_W-1:0] straps; // Captured straps
  logic straps_valid; // Capture done

  strap_capture u_straps (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .strap_pins_i({bios_select_n_i, rom_addr_low_i[1], rom_addr_top_i}),
    .straps_o(straps),
    .straps_valid_o(straps_valid)
  );

  // Strap meanings
  wire bios_large = straps[STRAP_ROM_TOP]; // RULE7
  wire pixel_on_upper = straps[STRAP_BIT1]; // RULE17
  wire bios_present = straps[STRAP_BIOS_CS]; // RULE16

  // ==========================================================
  // Function selection, test first
  wire in_test = test_mode_i; // RULE19
  wire in_vm = video_module_mode_i && !test_mode_i; // RULE19
  wire in_rom = !video_module_mode_i && !test_mode_i;
  wire strobe_style = (bus_style_i == STYLE_STROBE_DIR);

  // ==========================================================
  // Feature connector gating
  wire pix_drive = in_rom && !s_ven_n; // RULE1
  wire sync_drive = s_sben_n && !in_vm; // RULE2
  wire dot_clock_pin_drive = in_rom && !s_dcen_n; // RULE3

  // Dot clock pin out in feature mode only
  assign dot_clock_pin_o = '{out: dot_clock_i, oe: dot_clock_pin_drive}; // RULE4
  // Blank pin two-way, gated by sync enable
  assign blank_n_pin_o = '{out: blank_n_i, oe: sync_drive && in_rom}; // RULE5

  // Sync outputs, programmable polarity, float while enable low
  assign hsync_pin_o = '{out: hsync_i ^ sync_cfg_i.hsync_invert,
    oe: s_sben_n}; // RULE6
  assign vsync_pin_o = '{out: vsync_i ^ sync_cfg_i.vsync_invert,
    oe: s_sben_n}; // RULE6

  // Sync enable pin is GPIO in module mode
  assign sync_blank_enable_n_o = '{out: gpio_out_i,
    oe: in_vm && gpio_oe_i}; // RULE2

  // ==========================================================
  // Peripheral access sequencing
  typedef enum logic [1:0] {
    P_IDLE,
    P_WAIT,
    P_DONE
  } periph_state_t;
  periph_state_t pstate; // Access state
  periph_state_t next_pstate; // Next access state
  logic wr_lat; // Latched direction
  logic [3:0] addr_lat; // Latched register address
  logic [7:0] wdata_lat; // Latched write data
  logic [7:0] rdata; // Read data register

  // Ack low or ready high completes
  wire periph_ack = strobe_style ? !s_b4 : s_b4; // RULE12
  wire active = (pstate == P_WAIT);

  // Next-state decode
  always_comb begin
    next_pstate = pstate;
    case (pstate)
      P_IDLE: if (in_vm && periph_req_i) next_pstate = P_WAIT;
      P_WAIT: if (periph_ack || !in_vm) next_pstate = P_DONE; // RULE12
      P_DONE: next_pstate = P_IDLE;
      default: next_pstate = P_IDLE;
    endcase
  end

  // State and latches
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pstate <= P_IDLE;
      wr_lat <= 1'b0;
      addr_lat <= '0;
      wdata_lat <= '0;
      rdata <= '0;
    end else begin
      pstate <= next_pstate;
      if (pstate == P_IDLE && next_pstate == P_WAIT) begin
        wr_lat <= periph_write_i;
        addr_lat <= periph_reg_addr_i;
        wdata_lat <= periph_wdata_i;
      end
      if (active && periph_ack && !wr_lat) rdata <= s_data; // RULE15
    end
  end

  assign periph_done_o = (pstate == P_DONE);
  assign periph_rdata_o = rdata;

  // Strobe pins for either style, all active low
  wire strobe_b6 = strobe_style ? !active : !(active && !wr_lat); // RULE10
  wire strobe_b5 = strobe_style ? !wr_lat : !(active && wr_lat); // RULE11

  // ==========================================================
  // Shared address and data pins
  wire rom_cycle = in_rom && rom_read_i && bios_present;
  assign bios_select_n_o = '{out: !rom_cycle,
    oe: bios_present && straps_valid}; // RULE16

  // Top address: bit 15 or open-drain data; floats for strap
  assign rom_addr_top_o = '{out: bios_large ? rom_addr_i[15] : 1'b0,
    oe: (bios_large && in_rom && straps_valid) ||
    serial_data_drive_low_i}; // RULE7
  assign second_serial_clock_o = '{out: 1'b0,
    oe: serial_clock_drive_low_i}; // RULE8

  // Upper address: test, ROM address, pixel bus
  assign rom_addr_upper_o.out = in_test ? test_out_i[T_UPPER_LSB +: 8] :
    (pix_drive && pixel_on_upper && !rom_read_i) ? pixel_data_i :
    rom_addr_i[14:7]; // RULE9
  assign rom_addr_upper_o.oe = {UPPER_W{in_test ? test_oe_i :
    in_rom}}; // RULE9

  // Encoder bus becomes pixel bus when strapped
  assign encoder_video_bus_o.out = pixel_on_upper ? encoder_data_i :
    pixel_data_i; // RULE17
  assign encoder_video_bus_o.oe = {UPPER_W{pixel_on_upper ||
    pix_drive}}; // RULE17

  assign rom_addr_bit6_o = '{out: in_test ? test_out_i[T_RA6] :
    in_vm ? strobe_b6 : rom_addr_i[6], oe: in_test ? test_oe_i : 1'b1};
  assign rom_addr_bit5_o = '{out: in_test ? test_out_i[T_RA5] :
    in_vm ? strobe_b5 : rom_addr_i[5], oe: in_test ? test_oe_i : 1'b1};
  assign rom_addr_bit4_o = '{out: in_test ? test_out_i[T_RA4] :
    rom_addr_i[4], oe: in_test ? test_oe_i : in_rom}; // RULE12

  // Low pins carry register address
  assign rom_addr_low_o = in_test ? test_out_i[T_LOW_LSB +: LOW_W] :
    in_vm ? addr_lat : rom_addr_i[3:0]; // RULE13
  assign rom_addr_low_oe_o = {LOW_W{in_test ? test_oe_i : straps_valid}};
  assign rom_addr_mid_o = rom_addr_i[3:1];

  // Peripheral select low while an access runs
  assign periph_select_n_o = '{out: in_test ? test_out_i[T_SEL] :
    !active, oe: in_test ? test_oe_i : in_vm}; // RULE14

  // Data bus: test, write, else input
  assign periph_data_bus_o.out = in_test ?
    test_out_i[T_DATA_LSB +: 8] : wdata_lat; // RULE15
  assign periph_data_bus_o.oe = {ROM_DATA_W{in_test ? test_oe_i :
    (in_vm && active && wr_lat)}}; // RULE19

  // ==========================================================
  // Inputs back to the core
  assign rom_data_o = s_data;
  assign video_in_bus_o = in_vm ? s_upper : '0; // RULE9
  assign video_valid_in_o = in_vm && s_ven_n; // RULE1
  assign vertical_ref_o = in_vm && s_dcen_n; // RULE3
  assign horizontal_ref_o = in_vm && s_blank; // RULE5
  assign pixel_clock_in_o = in_vm && s_dot_clock_pin; // RULE4
  assign blank_in_o = s_blank;
  assign gpio_in_o = s_sben_n;
  assign serial_clock_in_o = s_scl;
  assign serial_data_in_o = s_top;
  assign bios_large_o = bios_large;
  assign bios_present_o = bios_present;
  assign encoder_video_ok_o = pixel_on_upper;
  assign test_in_o = {s_upper, 8'h00, s_psel, s_low, s_b4, s_b5, s_b6,
    s_data};

  // ==========================================================
  // Checks
  sequence access_start;
    pstate == P_IDLE && in_vm && periph_req_i;
  endsequence

  sync_float_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !s_sben_n |-> !hsync_pin_o.oe && !vsync_pin_o.oe) // RULE6
    else $error("sync driven while disabled");
  sync_polarity_a: assert property (@(posedge core_clk_i)
    disable iff (!nrst_i)
    hsync_pin_o.out == (hsync_i ^ sync_cfg_i.hsync_invert)) // RULE6
    else $error("hsync polarity wrong");
  dot_clock_pin_gate_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (in_vm || s_dcen_n) |-> !dot_clock_pin_o.oe) // RULE3
    else $error("dot clock driven while gated");
  test_wins_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    test_mode_i |-> periph_select_n_o.out == test_out_i[T_SEL]) // RULE19
    else $error("test bit lost on select");
  select_low_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    access_start |=> !periph_select_n_o.out) // RULE14
    else $error("select not low in access");
  ack_done_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (active && periph_ack) |=> periph_done_o ##1 !periph_done_o) // RULE12
    else $error("ack did not finish access");
  write_data_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (in_vm && active && wr_lat) |->
    periph_data_bus_o.oe == 8'hff) // RULE15
    else $error("write data not driven");
  rom_absent_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !bios_present |-> bios_select_n_o.oe == 1'b0) // RULE16
    else $error("absent ROM selected");
  pix_gate_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (!pixel_on_upper && !pix_drive) |-> encoder_video_bus_o.oe == 8'h00)
    // RULE17
    else $error("pixel bus driven while gated");

endmodule

// [periph_model.sv]
// Purpose: Behavioural peripheral on the module host port
// Assumes: Resolved pin levels
// Notes: Released data bus toggles
`timescale 1ns/10ps
module periph_model (
  input wire logic core_clk_i,
  input wire pin_mux_pkg::bus_style_t bus_style_i,
  input wire logic [3:0] wait_i,
  input wire logic select_n_i,
  input wire logic strobe_i,
  input wire logic dir_i,
  input wire logic [7:0] rdata_i,
  output logic ack_o,
  output logic [7:0] data_o
);
  import pin_mux_pkg::*;
  // ==========================================================
  // Access timing
  logic [4:0] cnt = 5'h00; // Cycles since select fell
  logic [7:0] last = 8'h00; // Last level put out on data_o
  wire hit = !select_n_i && (cnt >= {1'h0, wait_i});
  wire rd = (bus_style_i == STYLE_READ_WRITE) ? !strobe_i : dir_i;
  // Count selected cycles
  always @(posedge core_clk_i) begin
    if (select_n_i) begin
      cnt <= 5'h00;
    end else if (!hit) begin
      cnt <= cnt + 5'h01;
    end
    last <= data_o;
  end
  // Ack low or ready high
  assign ack_o = (bus_style_i == STYLE_READ_WRITE) ? hit : !hit;
  // Read data, else a toggling pattern
  assign data_o = (!select_n_i && rd) ? rdata_i : ~last;
endmodule

// [tb_rom_vmi_pin_mux.sv]
// Purpose: Self-checking bench for the pin mux
// Assumes: Inputs set on falling edges
// Notes: Rows for sync gating, hand tests after
`timescale 1ns/10ps
module tb_rom_vmi_pin_mux;
  import pin_mux_pkg::*;
  // ==========================================================
  // Port signals
  logic core_clk_i = 1'h0, nrst_i = 1'h0, video_module_mode_i = 1'h0;
  logic test_mode_i = 1'h0, rom_read_i = 1'h0, periph_req_i = 1'h0;
  logic periph_write_i = 1'h0, dot_clock_i = 1'h0, hsync_i = 1'h0;
  logic vsync_i = 1'h0, blank_n_i = 1'h1, gpio_out_i = 1'h0;
  logic gpio_oe_i = 1'h0, test_oe_i = 1'h0, video_enable_n_i = 1'h1;
  logic serial_clock_drive_low_i = 1'h0, serial_data_drive_low_i = 1'h0;
  logic dot_clock_enable_n_i = 1'h1;
  logic [7:0] periph_wdata_i = 8'h00, pixel_data_i = 8'h00;
  logic [7:0] encoder_data_i = 8'h00;
  logic [3:0] periph_reg_addr_i = 4'h0;
  logic [15:0] rom_addr_i = 16'h0000;
  logic [2:0] rom_addr_mid_i = 3'h0;
  logic [31:0] test_out_i = 32'h0;
  bus_style_t bus_style_i = STYLE_STROBE_DIR;
  sync_cfg_t sync_cfg_i = 2'h0;
  logic sync_blank_enable_n_i, dot_clock_pin_i, blank_n_pin_i;
  logic rom_addr_top_i, rom_addr_bit6_i, rom_addr_bit5_i, rom_addr_bit4_i;
  logic periph_select_n_i, bios_select_n_i, second_serial_clock_i;
  logic [7:0] rom_addr_upper_i, periph_data_bus_i;
  logic [3:0] rom_addr_low_i;
  logic bios_large_o, bios_present_o, encoder_video_ok_o, periph_done_o;
  logic video_valid_in_o, vertical_ref_o, horizontal_ref_o, blank_in_o;
  logic pixel_clock_in_o, gpio_in_o, serial_clock_in_o, serial_data_in_o;
  logic [7:0] rom_data_o, periph_rdata_o, video_in_bus_o;
  logic [3:0] rom_addr_low_o, rom_addr_low_oe_o;
  logic [2:0] rom_addr_mid_o;
  logic [31:0] test_in_o;
  pin_drv_t sync_blank_enable_n_o, dot_clock_pin_o, blank_n_pin_o;
  pin_drv_t hsync_pin_o, vsync_pin_o, rom_addr_top_o, rom_addr_bit6_o;
  pin_drv_t rom_addr_bit5_o, rom_addr_bit4_o, periph_select_n_o;
  pin_drv_t bios_select_n_o, second_serial_clock_o;
  bus8_drv_t rom_addr_upper_o, periph_data_bus_o, encoder_video_bus_o;
  // Board levels when undriven
  logic top_x = 1'h1, cs_x = 1'h1, scl_x = 1'h1, sen_x = 1'h1;
  logic dot_clock_pin_x = 1'h0, blank_x = 1'h1, ack;
  logic [3:0] low_x = 4'hf, pw = 4'h0;
  logic [7:0] up_x = 8'hff, rom_b = 8'h00, prd = 8'h00, pd;
  int err_total = 0, total_checks = 0;
  // Row: inputs, then {hs oe, hs, vs oe, vs, dot_clock_pin oe}
  typedef struct packed {
    logic sen_n, den_n;
    sync_cfg_t inv;
    logic hs, vs;
    logic [4:0] ex;
  } row_t;
  row_t rows [4] = '{'{1'h1, 1'h0, 2'h0, 1'h1, 1'h0, 5'h1d},
    '{1'h1, 1'h1, 2'h2, 1'h1, 1'h0, 5'h14},
    '{1'h1, 1'h0, 2'h1, 1'h0, 1'h0, 5'h17},
    '{1'h0, 1'h1, 2'h3, 1'h1, 1'h1, 5'h00}};
  // ==========================================================
  // Pin resolution
  function automatic logic pin(input pin_drv_t p, input logic x);
    return p.oe ? p.out : x;
  endfunction
  function automatic logic [7:0] bus(input bus8_drv_t b,
    input logic [7:0] x);
    return (b.oe & b.out) | (~b.oe & x);
  endfunction
  assign rom_addr_top_i = pin(rom_addr_top_o, top_x);
  assign second_serial_clock_i = pin(second_serial_clock_o, scl_x);
  assign sync_blank_enable_n_i = pin(sync_blank_enable_n_o, sen_x);
  assign dot_clock_pin_i = pin(dot_clock_pin_o, dot_clock_pin_x);
  assign blank_n_pin_i = pin(blank_n_pin_o, blank_x);
  assign bios_select_n_i = pin(bios_select_n_o, cs_x);
  assign periph_select_n_i = pin(periph_select_n_o, 1'h1);
  assign rom_addr_bit6_i = pin(rom_addr_bit6_o, 1'h1);
  assign rom_addr_bit5_i = pin(rom_addr_bit5_o, 1'h1);
  assign rom_addr_bit4_i = pin(rom_addr_bit4_o, ack);
  assign rom_addr_upper_i = bus(rom_addr_upper_o, up_x);
  assign rom_addr_low_i = (rom_addr_low_oe_o & rom_addr_low_o)
    | (~rom_addr_low_oe_o & low_x);
  // ROM drives while selected
  assign periph_data_bus_i = bus(periph_data_bus_o,
    (bios_select_n_i == 1'h0) ? rom_b : pd);
  rom_vmi_pin_mux i_rom_vmi_pin_mux (.*);
  periph_model i_periph_model (
    .core_clk_i(core_clk_i), .bus_style_i(bus_style_i), .wait_i(pw),
    .select_n_i(periph_select_n_i), .strobe_i(rom_addr_bit6_i),
    .dir_i(rom_addr_bit5_i), .rdata_i(prd), .ack_o(ack), .data_o(pd));
  always #5 core_clk_i = ~core_clk_i;
  // ==========================================================
  // Tasks
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bounded wait for done
  task automatic wdone(input int n);
    for (int k = 0; k < n && periph_done_o !== 1'h1; k++) wt(1);
    chk("done", 1'h1, periph_done_o);
    if (periph_done_o !== 1'h1) end_sim;
  endtask
  // Reset with straps, then flip pins
  task automatic rst(input logic t, b, c);
    {top_x, low_x, cs_x} = {t, 2'h3, b, 1'h1, c};
    nrst_i = 1'h0;
    wt(2);
    chk("strap rst", 3'h7, {bios_present_o, encoder_video_ok_o,
      bios_large_o});
    nrst_i = 1'h1;
    wt(5);
    {top_x, low_x, cs_x} = {!t, 2'h3, !b, 1'h1, !c};
    wt(3);
    chk("straps", {c, b, t}, {bios_present_o, encoder_video_ok_o,
      bios_large_o});
  endtask
  // One access; pins checked in first select cycle
  task automatic acc(input logic s, w, input logic [3:0] a, n,
    input logic [7:0] d);
    bus_style_i = bus_style_t'(s);
    wt(3);
    {periph_write_i, periph_reg_addr_i, periph_wdata_i} = {w, a, d};
    {pw, prd, periph_req_i} = {n, ~d, 1'h1};
    wt(1);
    periph_req_i = 1'h0;
    chk("sel", 2'h1, periph_select_n_o);
    chk("haddr", a, rom_addr_low_o);
    chk("dir", !w, rom_addr_bit5_o.out);
    chk("strb", s & w, rom_addr_bit6_o.out);
    chk("hd oe", {8{w}}, periph_data_bus_o.oe);
    if (w) chk("hd", d, periph_data_bus_o.out);
    wdone(20);
    wt(1);
    if (!w) chk("rdata", prd, periph_rdata_o);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    row_t r;
    rst(1'h1, 1'h1, 1'h1);
    // Sync and dot clock gating
    foreach (rows[i]) begin
      r = rows[i];
      {sen_x, dot_clock_enable_n_i, sync_cfg_i} = {r.sen_n, r.den_n, r.inv};
      {hsync_i, vsync_i, dot_clock_i} = {r.hs, r.vs, r.hs};
      wt(4);
      chk("hs oe", r.ex[4], hsync_pin_o.oe);
      chk("vs oe", r.ex[2], vsync_pin_o.oe);
      chk("dot_clock_pin oe", r.ex[0], dot_clock_pin_o.oe);
      if (r.ex[4]) chk("hs", r.ex[3], hsync_pin_o.out);
      if (r.ex[2]) chk("vs", r.ex[1], vsync_pin_o.out);
      if (r.ex[0]) chk("dot_clock_pin", r.hs, dot_clock_pin_o.out);
      chk("sync_blank_enable_n oe", 1'h0, sync_blank_enable_n_o.oe);
      chk("vid", 8'h00, video_in_bus_o);
    end
    // BIOS read with a large ROM present
    {rom_b, rom_addr_i, rom_read_i} = {8'h6e, 16'h8a53, 1'h1};
    wt(4);
    chk("bios_select_n", 2'h1, bios_select_n_o);
    chk("rom_addr_top", 1'h1, rom_addr_top_o.out);
    chk("rom data", 8'h6e, rom_data_o);
    // Small ROM, encoder pixel bus, no ROM
    rst(1'h0, 1'h0, 1'h0);
    {video_enable_n_i, pixel_data_i} = {1'h0, 8'ha6};
    {serial_data_drive_low_i, serial_clock_drive_low_i} = 2'h3;
    wt(4);
    chk("ev", 16'ha6ff, encoder_video_bus_o);
    chk("no rom", 1'h0, bios_select_n_o.oe & ~bios_select_n_o.out);
    chk("sda", 2'h1, rom_addr_top_o);
    chk("scl", 2'h1, second_serial_clock_o);
    chk("scl in", 1'h0, serial_clock_in_o);
    {video_enable_n_i, serial_data_drive_low_i} = 2'h2;
    serial_clock_drive_low_i = 1'h0;
    wt(4);
    chk("ev oe", 8'h00, encoder_video_bus_o.oe);
    chk("sda oe", 1'h0, rom_addr_top_o.oe);
    chk("sda in", 1'h1, serial_data_in_o);
    chk("scl in", 1'h1, serial_clock_in_o);
    // Request outside module mode is ignored
    {rom_read_i, periph_req_i} = 2'h1;
    wt(4);
    periph_req_i = 1'h0;
    chk("no sel", 1'h0, periph_select_n_o.oe & ~periph_select_n_o.out);
    // Module mode pin roles
    {video_module_mode_i, gpio_oe_i, dot_clock_enable_n_i} = 3'h6;
    {dot_clock_pin_x, blank_x, up_x} = {1'h1, 1'h0, 8'h3c};
    wt(4);
    chk("gpio", 2'h1, sync_blank_enable_n_o);
    chk("valid", 1'h1, video_valid_in_o);
    chk("vref", 1'h0, vertical_ref_o);
    chk("pclk", 1'h1, pixel_clock_in_o);
    chk("dot_clock_pin in", 1'h0, dot_clock_pin_o.oe);
    chk("href", 1'h0, horizontal_ref_o);
    chk("blank in", 1'h0, blank_n_pin_o.oe);
    chk("vid", 8'h3c, video_in_bus_o);
    {gpio_oe_i, sen_x} = 2'h0;
    wt(4);
    chk("gpio in", 1'h0, gpio_in_o);
    // Accesses in both styles
    acc(1'h0, 1'h1, 4'h9, 4'h0, 8'h5a);
    acc(1'h0, 1'h0, 4'h6, 4'h5, 8'h33);
    acc(1'h1, 1'h0, 4'hf, 4'h2, 8'hc4);
    acc(1'h1, 1'h1, 4'h0, 4'h7, 8'h81);
    // Leaving module mode ends access
    {pw, periph_write_i, periph_req_i} = {4'hf, 2'h1};
    wt(1);
    periph_req_i = 1'h0;
    wt(2);
    video_module_mode_i = 1'h0;
    wdone(6);
    // Test bus wins over module mode
    {test_mode_i, video_module_mode_i, test_oe_i} = 3'h7;
    for (int k = 0; k < 2; k++) begin
      test_out_i = k ? 32'h693ca5c3 : 32'h96c35a3c;
      wt(3);
      chk("t up", {test_out_i[31:24], 8'hff}, rom_addr_upper_o);
      chk("t8", {test_out_i[T_RA6], 1'h1}, rom_addr_bit6_o);
      chk("t9", {test_out_i[T_RA5], 1'h1}, rom_addr_bit5_o);
      chk("t lo", test_out_i[14:11], rom_addr_low_o);
      chk("t15", {test_out_i[T_SEL], 1'h1}, periph_select_n_o);
      chk("t lsb", {test_out_i[7:0], 8'hff}, periph_data_bus_o);
      chk("t in", {test_out_i[31:24], 8'h00, test_out_i[15:0]},
        test_in_o);
    end
    end_sim;
  end
endmodule
